// *** dv/pfs_fault_supervisor_assertions.sv ***
/*
  Port checker for the fault supervisor top module.
  Assumes it is bound onto that module and sees its ports only.
*/
`timescale 1ns/10ps
module pfs_fault_supervisor_assertions
  #(parameter int HOLDOFF_CYCLES = 4000000)
  (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Watched inputs
  input wire logic ctrl_pin,
  input wire logic [4:0] vin_above_rise,
  input wire logic [4:0] vin_above_fall,
  input wire logic thermal_shutdown_trip,
  // Watched outputs
  input wire logic sda_oe,
  input wire logic [6:0] reg_en,
  input wire logic [6:0] ilim_sel,
  input wire logic fault_int_pin
  );
  // ****************************************************************
  // Helpers
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] quiet_cnt;
  logic [31:0] hold_cnt;
  // Cycles since an ack or control low
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      quiet_cnt <= 4'hF;
    else if (!ctrl_pin || sda_oe)
      quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hF)
      quiet_cnt <= quiet_cnt + 4'h1;
  // Cycles since input 2 fell
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      hold_cnt <= '1;
    else if (!ctrl_pin)
      hold_cnt <= '1;
    else if ($fell(vin_above_fall[2]))
      hold_cnt <= 32'h0;
    else if (hold_cnt != '1)
      hold_cnt <= hold_cnt + 32'h1;
  // ****************************************************************
  // Sequences and assertions
  // ****************************************************************
  sequence s_ctrl_on;
    ctrl_pin [*4];
  endsequence
  sequence s_tsd_entry;
    s_ctrl_on ##0 $rose(thermal_shutdown_trip)
      ##1 (ctrl_pin && thermal_shutdown_trip) [*6];
  endsequence
  sequence s_rise_drop;
    s_ctrl_on ##0 (|(~vin_above_rise & $past(vin_above_rise)))
      ##1 ctrl_pin [*6];
  endsequence
  sequence s_fall_drop;
    s_ctrl_on ##0 $fell(vin_above_fall[2])
      ##1 (ctrl_pin && !vin_above_fall[2]) [*6];
  endsequence
  a_ctrl_low_clear: assert property (
    !ctrl_pin [*8] |-> reg_en == 7'h00 && !fault_int_pin)
    else $error("Control low left outputs active");
  a_tsd_all_off: assert property (
    thermal_shutdown_trip [*6] |-> reg_en == 7'h00)
    else $error("Regulator on during thermal shutdown");
  a_tsd_int_pin: assert property (
    s_tsd_entry |-> fault_int_pin)
    else $error("No interrupt after thermal shutdown");
  a_lockout_int_pin: assert property (
    s_rise_drop |-> fault_int_pin)
    else $error("No interrupt after input lockout");
  a_lockout_shut: assert property (
    s_fall_drop |-> !reg_en[4])
    else $error("Regulator 4 still on after input drop");
  a_holdoff_min: assert property (
    $rose(reg_en[4]) |-> hold_cnt >= HOLDOFF_CYCLES)
    else $error("Restart before hold-off ran out");
  a_ilim_by_write: assert property (
    $changed(ilim_sel) && $past(resetn, 2) |-> sda_oe)
    else $error("Current limit changed without a bus write");
  a_pin_release: assert property (
    $fell(fault_int_pin) |-> quiet_cnt < 4'h6)
    else $error("Interrupt pin fell without read or control low");
endmodule
bind pfs_fault_supervisor pfs_fault_supervisor_assertions
  #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) i_pfs_chk (
  .ref_clk(ref_clk), .resetn(resetn), .ctrl_pin(ctrl_pin),
  .vin_above_rise(vin_above_rise), .vin_above_fall(vin_above_fall),
  .thermal_shutdown_trip(thermal_shutdown_trip), .sda_oe(sda_oe),
  .reg_en(reg_en), .ilim_sel(ilim_sel), .fault_int_pin(fault_int_pin));

// *** dv/pfs_host_model.sv ***
/*
  Host model: two-wire serial master with byte write and read tasks.
  Assumes the bench resolves SDA from both open-drain drivers.
*/
`timescale 1ns/10ps
module pfs_host_model
  import pfs_pkg::*;
  (
  // Clock
  input wire logic ref_clk,
  // Serial lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda_w
  );
  int n_nack = 0;
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Lines stand high outside frames
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Quarter bit, well above the sync delay
  task automatic q();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  task automatic put(input logic b);
    sda_drv = b;
    q();
    scl = 1'b1;
    q();
    q();
    scl = 1'b0;
    q();
  endtask
  // Release SDA, sample it in mid-high
  task automatic get(output logic b);
    sda_drv = 1'b1;
    q();
    scl = 1'b1;
    q();
    b = sda_w;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic start();
    sda_drv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  // Byte MSB first; a missing ack is counted
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--)
      put(d[i]);
    get(a);
    if (a)
      n_nack++;
  endtask
  task automatic head(input logic [7:0] a);
    start();
    send({PFS_SLAVE_ADDR, 1'b0});
    send(a);
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b1;
    q();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    head(a);
    send(d);
    stop();
  endtask
  // Repeated start, one byte, master nack ends the read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    head(a);
    start();
    send({PFS_SLAVE_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--)
      get(d[i]);
    put(1'b1);
    stop();
  endtask
endmodule

// *** dv/test_pfs_fault_supervisor.sv ***
/*
  Self-checking bench for the fault supervisor and the host model.
  Assumes a restart hold-off shortened to 50 clock cycles.
*/
`timescale 1ns/10ps
module test_pfs_fault_supervisor
  import pfs_pkg::*;
  ;
  localparam int HOLD = 50;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ctrl_pin = 1'b1;
  logic [4:0] vin_rise = 5'h1F, vin_fall = 5'h1F;
  logic warn_trip = 1'b0, warn_rel = 1'b0, tsd_trip = 1'b0;
  logic scl, sda_drv, sda_o, sda_oe, fault_int_pin;
  logic [6:0] reg_en, ilim_sel;
  logic [7:0] d;
  int n_mismatch = 0;
  int compares = 0;
  // ****************************************************************
  // Clock, wiring, instances
  // ****************************************************************
  always #2.5 ref_clk = ~ref_clk;
  // Pulled-up SDA
  wire sda_w = sda_drv & ~(sda_oe & ~sda_o);
  pfs_fault_supervisor #(.HOLDOFF_CYCLES(HOLD)) i_pfs_fault_supervisor (
    .ref_clk(ref_clk), .resetn(resetn), .ctrl_pin(ctrl_pin),
    .system_bias_supply_above_por(1'b1),
    .system_bias_supply_above_rise(1'b1),
    .system_bias_supply_above_fall(1'b1),
    .vin_above_rise(vin_rise), .vin_above_fall(vin_fall),
    .thermal_warning_trip(warn_trip), .thermal_warning_release(warn_rel),
    .thermal_shutdown_trip(tsd_trip), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .reg_en(reg_en),
    .ilim_sel(ilim_sel), .fault_int_pin(fault_int_pin));
  pfs_host_model i_pfs_host_model (
    .ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_w(sda_w));
  // ****************************************************************
  // Helpers and scenarios
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cen(input logic [7:0] e);
    chk({1'b0, reg_en}, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_pfs_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic t_regs();
    rchk(PFS_OFF_ILIM, PFS_ILIM_RST);
    i_pfs_host_model.wr(PFS_OFF_ILIM, 8'hAC);
    chk({1'b0, ilim_sel}, 8'h2C);
    rchk(PFS_OFF_ILIM, 8'h2C);
    chk(i_pfs_host_model.n_nack[7:0], 8'h00);
    rchk(8'h3C, 8'h00);
    i_pfs_host_model.wr(PFS_OFF_ENABLE, 8'hFF);
    cen(8'h7F);
    $display("t_regs done");
  endtask
  task automatic t_lockout();
    vin_rise[2] = 1'b0;
    cyc(10);
    chk({7'h00, fault_int_pin}, 8'h01);
    rchk(PFS_OFF_STAT, 8'h08);
    vin_fall[2] = 1'b0;
    cyc(10);
    cen(8'h6F);
    rchk(PFS_OFF_SUSP, 8'h10);
    cen(8'h6F);
    vin_fall[2] = 1'b1;
    vin_rise[2] = 1'b1;
    cyc(10);
    cen(8'h7F);
    rchk(PFS_OFF_STAT, 8'h00);
    rchk(PFS_OFF_SUSP, 8'h00);
    rchk(PFS_OFF_INTR, 8'h08);
    rchk(PFS_OFF_INTR, 8'h00);
    chk({7'h00, fault_int_pin}, 8'h00);
    // Three more drops: the fourth fault must latch regulator 4 off
    for (int i = 0; i < 3; i++)
    begin
      vin_rise[2] = 1'b0;
      vin_fall[2] = 1'b0;
      cyc(10);
      vin_rise[2] = 1'b1;
      vin_fall[2] = 1'b1;
      cyc(20);
      chk({7'h00, reg_en[4]}, 8'h00);
      cyc(70);
      chk({7'h00, reg_en[4]}, {7'h00, i < 2});
    end
    $display("t_lockout done");
  endtask
  task automatic t_ctrl();
    chk({7'h00, fault_int_pin}, 8'h01);
    ctrl_pin = 1'b0;
    cyc(10);
    cen(8'h00);
    chk({7'h00, fault_int_pin}, 8'h00);
    rchk(PFS_OFF_INTR, 8'h00);
    rchk(PFS_OFF_ILIM, 8'h2C);
    ctrl_pin = 1'b1;
    cyc(80);
    cen(8'h7F);
    $display("t_ctrl done");
  endtask
  task automatic t_thermal();
    warn_trip = 1'b1;
    warn_rel = 1'b1;
    cyc(10);
    rchk(PFS_OFF_STAT, 8'h80);
    tsd_trip = 1'b1;
    cyc(10);
    cen(8'h00);
    chk({7'h00, fault_int_pin}, 8'h01);
    rchk(PFS_OFF_SUSP, 8'h80);
    tsd_trip = 1'b0;
    warn_trip = 1'b0;
    rchk(PFS_OFF_STAT, 8'hC0);
    rchk(PFS_OFF_INTR, 8'h40);
    warn_rel = 1'b0;
    cyc(10);
    rchk(PFS_OFF_STAT, 8'h00);
    rchk(PFS_OFF_SUSP, 8'h00);
    cen(8'h7F);
    $display("t_thermal done");
  endtask
  task automatic stop_test();
    $display("Counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence after three cycles of reset
  initial
  begin
    cyc(3);
    resetn = 1'b1;
    cyc(6);
    t_regs();
    t_lockout();
    t_ctrl();
    t_thermal();
    stop_test();
  end
  // Watchdog, about two and a half times the expected run
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    $display("Watchdog expired");
    n_mismatch++;
    stop_test();
  end
endmodule

// *** rtl/pfs_fault_supervisor.sv ***
/*
  Fault supervisor of a seven-regulator power chip:
  lockout, hold-off, fault counts, thermal trips,
  interrupt, status and suspend registers on a two-wire port.
  Assumes comparator flags and pins are asynchronous levels;
  enables and current-limit selects go to analog blocks.
*/
// How it works
// - Input low sets lockout int and status
// - Status stays while input below rise
// - Falling trip shuts regulators, sets int
// - Recovery clears status, allows restart
// - Lockout shutdown sets suspend bits
// - Off 20 ms, restart only if recovered
// - Restart clears suspend bits
// - Fourth fault latches regulators off
// - Warning status held until release
// - Thermal trip: all off, int, bus alive
// - Shutdown status held while warning
// - Thermal shutdown sets chip suspend
// - One current-limit bit per regulator
// - Pin low only when all ints clear
// - Reading an interrupt bit clears it
// - Cooling clears thermal bits, restores
// - Control low clears ints, status, counts
`timescale 1ns/10ps
module pfs_fault_supervisor
  import pfs_pkg::*;
  #(parameter int HOLDOFF_CYCLES = PFS_HOLD_CYC)
  (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control pin
  input wire logic ctrl_pin,
  // Supply comparators, high means above the level
  input wire logic system_bias_supply_above_por,
  input wire logic system_bias_supply_above_rise,
  input wire logic system_bias_supply_above_fall,
  input wire logic [4:0] vin_above_rise,
  input wire logic [4:0] vin_above_fall,
  // Temperature comparators
  input wire logic thermal_warning_trip,
  input wire logic thermal_warning_release,
  input wire logic thermal_shutdown_trip,
  // Serial port pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Regulator controls
  output logic [6:0] reg_en,
  output logic [6:0] ilim_sel,
  // Fault interrupt pin
  output logic fault_int_pin
  );

  // ****************************************************************
  // Synchronised inputs
  // ****************************************************************
  logic [PFS_NSYNC-1:0] flags_s;
  logic [1:0] pins_s;
  logic ctrl_s, por_s, sys_rise_s, sys_fall_s;
  logic [4:0] vin_rise_s, vin_fall_s;
  logic warn_s, release_s, sd_s;
  logic [PFS_NSRC-1:0] src_rise, src_fall, src_armed;

  pfs_sync #(.W(PFS_NSYNC)) u_flag_sync
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({ctrl_pin, system_bias_supply_above_por,
      system_bias_supply_above_rise, system_bias_supply_above_fall,
      vin_above_rise, vin_above_fall, thermal_warning_trip,
      thermal_warning_release, thermal_shutdown_trip}),
    .sync_out(flags_s)
  );

  pfs_sync #(.W(2)) u_pin_sync
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({scl_i, sda_i}),
    .sync_out(pins_s)
  );

  assign {ctrl_s, por_s, sys_rise_s, sys_fall_s, vin_rise_s, vin_fall_s,
    warn_s, release_s, sd_s} = flags_s;
  assign src_rise = {vin_rise_s, sys_rise_s};
  assign src_fall = {vin_fall_s, sys_fall_s};
  // Bias lockout counts only past power-on level
  assign src_armed = {5'h1F, por_s};

  // ****************************************************************
  // Serial register port
  // ****************************************************************
  logic wr_stb, rd_stb;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;

  pfs_i2c_slave u_port
  (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .scl_s(pins_s[1]),
    .sda_s(pins_s[0]),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Shared address decode
  function automatic logic addr_is(input logic [7:0] a,
    input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  // ****************************************************************
  // Lockout sources
  // ****************************************************************
  logic [PFS_NSRC-1:0] src_below, src_int_set, src_fall_evt;
  logic [PFS_NSRC-1:0] src_restart, src_off;

  genvar g;
  generate
    for (g = 0; g < PFS_NSRC; g = g + 1)
    begin : g_src
      logic shut_r, lat_r, fall_prev_r, below_prev_r;
      logic [2:0] cnt_r;
      logic [PFS_HOLD_W-1:0] hold_r;

      assign src_below[g] = ctrl_s & src_armed[g] & ~src_rise[g];
      assign src_int_set[g] = (src_below[g] & ~below_prev_r) |
        src_fall_evt[g];
      assign src_fall_evt[g] = ctrl_s & fall_prev_r & ~src_fall[g] &
        ~shut_r;
      // Restart needs expired hold-off, recovered input
      assign src_restart[g] = ctrl_s & shut_r & ~lat_r &
        (hold_r == '0) & src_rise[g];
      assign src_off[g] = shut_r | lat_r;

      // Shutdown, hold-off and fault count per source
      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          shut_r <= 1'b0;
          lat_r <= 1'b0;
          cnt_r <= 3'h0;
          hold_r <= '0;
          fall_prev_r <= 1'b0;
          below_prev_r <= 1'b0;
        end
        else
        begin
          fall_prev_r <= src_fall[g];
          below_prev_r <= src_below[g];
          if (!ctrl_s)
          begin
            shut_r <= 1'b0;
            lat_r <= 1'b0;
            cnt_r <= 3'h0;
            hold_r <= '0;
          end
          else if (src_fall_evt[g])
          begin
            shut_r <= 1'b1;
            hold_r <= PFS_HOLD_W'(HOLDOFF_CYCLES);
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r + 3'h1 == PFS_FAULT_LIMIT)
              lat_r <= 1'b1;
          end
          else if (src_restart[g])
            shut_r <= 1'b0;
          else if (hold_r != '0)
            hold_r <= hold_r - PFS_HOLD_W'(1);
        end
      end
    end
  endgenerate

  // Fold sources onto the regulators they feed
  logic [6:0] off_mask, susp_set, susp_clr;

  always_comb
  begin
    off_mask = 7'h00;
    susp_set = 7'h00;
    susp_clr = 7'h00;
    for (int i = 0; i < PFS_NSRC; i++)
    begin
      if (src_off[i])
        off_mask = off_mask | pfs_src_regs(i);
      if (src_fall_evt[i])
        susp_set = susp_set | pfs_src_regs(i);
      if (src_restart[i])
        susp_clr = susp_clr | pfs_src_regs(i);
    end
  end

  // ****************************************************************
  // Thermal supervision
  // ****************************************************************
  logic warn_r, tsd_r, sd_prev_r, tsd_evt;

  assign tsd_evt = ctrl_s & sd_s & ~sd_prev_r;

  // Warning with hysteresis; shutdown held until warning releases
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      warn_r <= 1'b0;
      tsd_r <= 1'b0;
      sd_prev_r <= 1'b0;
    end
    else
    begin
      sd_prev_r <= sd_s;
      if (!ctrl_s)
      begin
        warn_r <= 1'b0;
        tsd_r <= 1'b0;
      end
      else
      begin
        if (warn_s)
          warn_r <= 1'b1;
        else if (!release_s)
          warn_r <= 1'b0;
        if (tsd_evt)
          tsd_r <= 1'b1;
        else if (!warn_r)
          tsd_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt, status and suspend registers
  // ****************************************************************
  logic [6:0] int_r, susp_r, int_clr;
  logic [5:0] stat_r;

  // Clear only what the host captured; a new event in that cycle stays
  assign int_clr = (rd_stb && addr_is(rd_addr, PFS_OFF_INTR)) ?
    int_r : 7'h00;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_r <= 7'h00;
      stat_r <= 6'h00;
      susp_r <= 7'h00;
    end
    else if (!ctrl_s)
    begin
      int_r <= 7'h00;
      stat_r <= 6'h00;
      susp_r <= 7'h00;
    end
    else
    begin
      int_r <= (int_r & ~int_clr) | {tsd_evt, src_int_set};
      stat_r <= src_below;
      susp_r <= (susp_r & ~susp_clr) | susp_set;
    end
  end

  // ****************************************************************
  // Host-written registers
  // ****************************************************************
  logic [7:0] ilim_r, enable_r;

  // Kept through control low; only the port writes
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ilim_r <= PFS_ILIM_RST;
      enable_r <= PFS_ENABLE_RST;
    end
    else if (wr_stb)
    begin
      if (addr_is(wr_addr, PFS_OFF_ILIM))
        ilim_r <= wr_data & PFS_ILIM_MASK;
      if (addr_is(wr_addr, PFS_OFF_ENABLE))
        enable_r <= wr_data;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (rd_addr)
      PFS_OFF_DEV_ID: rd_data = PFS_DEV_ID_VAL;
      PFS_OFF_REV_ID: rd_data = PFS_REV_ID_VAL;
      PFS_OFF_ILIM: rd_data = ilim_r;
      PFS_OFF_ENABLE: rd_data = enable_r;
      PFS_OFF_INTR: rd_data = {1'b0, int_r};
      PFS_OFF_STAT: rd_data = {warn_r, tsd_r, stat_r};
      PFS_OFF_SUSP: rd_data = {tsd_r, susp_r};
      default: rd_data = 8'h00;
    endcase
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Enables come back by themselves once faults clear, except those latched off by a fourth fault, so the
  // pre-shutdown state is restored without software help
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_en <= 7'h00;
      ilim_sel <= 7'h00;
      fault_int_pin <= 1'b0;
    end
    else
    begin
      reg_en <= (ctrl_s & ~tsd_r & ~tsd_evt) ?
        (enable_r[6:0] & ~off_mask) : 7'h00;
      ilim_sel <= ilim_r[6:0];
      fault_int_pin <= |int_r;
    end
  end

endmodule

// *** rtl/pfs_i2c_slave.sv ***
/*
  Two-wire serial slave: address match, register pointer, sequential
  writes and reads. Assumes SCL and SDA already synchronised to ref_clk;
  read data arrives combinationally for the address on rd_addr.
*/
`timescale 1ns/10ps
module pfs_i2c_slave
  import pfs_pkg::*;
  (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Synchronised pins
  input wire logic scl_s,
  input wire logic sda_s,
  // Open-drain data drive
  output logic sda_o,
  output logic sda_oe,
  // Register write
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // Register read
  output logic rd_stb,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
  );

  pfs_phase_t phase_r;
  logic scl_prev_r, sda_prev_r, ack_r, rw_r, mack_r, drive_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shreg_r, ptr_r;
  logic scl_rise, scl_fall, start_c, stop_c;

  // ****************************************************************
  // Bus conditions
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_r;
  assign scl_fall = ~scl_s & scl_prev_r;
  assign start_c = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  assign stop_c = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

  // Load a read byte after the address ack or a master ack
  assign rd_stb = scl_fall & ack_r & ~start_c & ~stop_c &
    (((phase_r == PFS_PH_DEV) & rw_r) |
     ((phase_r == PFS_PH_RDATA) & mack_r));
  assign rd_addr = ptr_r;
  assign sda_o = 1'b0;
  assign sda_oe = drive_r;

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_r <= PFS_PH_IDLE;
      bit_cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      ptr_r <= 8'h00;
      ack_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      drive_r <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (start_c)
      begin
        phase_r <= PFS_PH_DEV;
        bit_cnt_r <= 4'h0;
        ack_r <= 1'b0;
        drive_r <= 1'b0;
      end
      else if (stop_c)
      begin
        phase_r <= PFS_PH_IDLE;
        ack_r <= 1'b0;
        drive_r <= 1'b0;
      end
      else if (phase_r != PFS_PH_IDLE && scl_rise)
      begin
        if (ack_r)
          mack_r <= ~sda_s;
        else
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (phase_r != PFS_PH_RDATA)
            shreg_r <= {shreg_r[6:0], sda_s};
        end
      end
      else if (phase_r != PFS_PH_IDLE && scl_fall)
      begin
        if (ack_r)
        begin
          ack_r <= 1'b0;
          drive_r <= 1'b0;
          if (rd_stb)
          begin
            // Capture exactly what the register file shows now
            phase_r <= PFS_PH_RDATA;
            shreg_r <= rd_data;
            drive_r <= ~rd_data[7];
            ptr_r <= ptr_r + 8'h01;
          end
          else if (phase_r == PFS_PH_DEV)
            phase_r <= PFS_PH_REG;
          else if (phase_r == PFS_PH_REG)
            phase_r <= PFS_PH_WDATA;
          else if (phase_r == PFS_PH_RDATA)
            phase_r <= PFS_PH_IDLE; // Master refused more data
        end
        else if (bit_cnt_r == PFS_BITS_PER_BYTE)
        begin
          bit_cnt_r <= 4'h0;
          ack_r <= 1'b1;
          drive_r <= (phase_r != PFS_PH_RDATA);
          mack_r <= 1'b0;
          case (phase_r)
            PFS_PH_DEV:
            begin
              if (shreg_r[7:1] == PFS_SLAVE_ADDR)
                rw_r <= shreg_r[0];
              else
              begin
                phase_r <= PFS_PH_IDLE;
                ack_r <= 1'b0;
                drive_r <= 1'b0;
              end
            end
            PFS_PH_REG: ptr_r <= shreg_r;
            PFS_PH_WDATA:
            begin
              wr_stb <= 1'b1;
              wr_addr <= ptr_r;
              wr_data <= shreg_r;
              ptr_r <= ptr_r + 8'h01;
            end
            default: ;
          endcase
        end
        else if (phase_r == PFS_PH_RDATA)
        begin
          shreg_r <= {shreg_r[6:0], 1'b0};
          drive_r <= ~shreg_r[6];
        end
      end
    end
  end

endmodule

// *** rtl/pfs_pkg.sv ***
/*
  Shared constants of the fault supervisor: offsets, reset values,
  fields, timing counts and serial-port phases.
  Assumes a single 200 MHz clock domain for every user of this package.
*/
package pfs_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PFS_NSRC = 6;  // Bias supply plus five regulator inputs
  localparam int PFS_NREG = 7;  // Regulator outputs
  localparam int PFS_NSYNC = 17; // Asynchronous flags into the clock domain

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] PFS_OFF_DEV_ID = 8'h00;
  localparam logic [7:0] PFS_OFF_REV_ID = 8'h01;
  localparam logic [7:0] PFS_OFF_ILIM = 8'h02;
  localparam logic [7:0] PFS_OFF_ENABLE = 8'h03;
  localparam logic [7:0] PFS_OFF_INTR = 8'h04;
  localparam logic [7:0] PFS_OFF_STAT = 8'h05;
  localparam logic [7:0] PFS_OFF_SUSP = 8'h06;

  // ****************************************************************
  // Reset and fixed values
  // ****************************************************************
  localparam logic [7:0] PFS_ILIM_RST = 8'h53;
  localparam logic [7:0] PFS_ILIM_MASK = 8'h7F; // Top bit reads zero
  localparam logic [7:0] PFS_ENABLE_RST = 8'h80;
  localparam logic [7:0] PFS_DEV_ID_VAL = 8'h5A; // Arbitrary value
  localparam logic [7:0] PFS_REV_ID_VAL = 8'h0A; // Arbitrary value
  localparam logic [6:0] PFS_SLAVE_ADDR = 7'h35;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PFS_BIT_TSD = 6;   // Thermal shutdown, int and status
  localparam int PFS_BIT_WARN = 7;  // Thermal warning, status
  localparam int PFS_BIT_CHIP = 7;  // Chip suspend, suspend register

  // ****************************************************************
  // Timing and counts
  // ****************************************************************
  localparam int PFS_CLK_MHZ = 200;
  localparam int PFS_HOLD_US = 20000; // Restart hold-off, 20 ms
  localparam int PFS_HOLD_CYC = PFS_HOLD_US * PFS_CLK_MHZ;
  localparam int PFS_HOLD_W = 23;
  localparam logic [2:0] PFS_FAULT_LIMIT = 3'h4;
  localparam logic [3:0] PFS_BITS_PER_BYTE = 4'h8;

  // ****************************************************************
  // Serial-port phases
  // ****************************************************************
  typedef enum logic [2:0]
  {
    PFS_PH_IDLE = 3'b000,
    PFS_PH_DEV = 3'b001,
    PFS_PH_REG = 3'b010,
    PFS_PH_WDATA = 3'b011,
    PFS_PH_RDATA = 3'b100
  } pfs_phase_t;

  // Regulators fed by each lockout source; source 0 is the bias supply
  function automatic logic [6:0] pfs_src_regs(input int src);
    case (src)
      0: pfs_src_regs = 7'h7F;
      1: pfs_src_regs = 7'h03;
      2: pfs_src_regs = 7'h0C;
      3: pfs_src_regs = 7'h10;
      4: pfs_src_regs = 7'h20;
      5: pfs_src_regs = 7'h40;
      default: pfs_src_regs = 7'h00;
    endcase
  endfunction

endpackage

// *** rtl/pfs_sync.sv ***
/*
  Two-flop synchroniser for a vector of independent level signals.
  Assumes each bit is a slow level; multi-bit coherence is not kept.
*/
`timescale 1ns/10ps
module pfs_sync
  #(parameter int W = 1)
  (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
  );

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
